// >>> include/ntc_pkg.sv
// Constants for the non-temporal store, prefetch and fence unit
package ntc_pkg;
    // Operation codes on the issue port
    localparam logic [2:0] OP_NT_STORE_QUADWORD = 3'h0;
    localparam logic [2:0] OP_NT_STORE_PACKED_SINGLE = 3'h1;
    localparam logic [2:0] OP_MASKED_BYTE_STORE_QUADWORD = 3'h2;
    localparam logic [2:0] OP_PREFETCH_ALL_LEVELS = 3'h3;
    localparam logic [2:0] OP_PREFETCH_LEVEL_TWO_UP_A = 3'h4;
    localparam logic [2:0] OP_PREFETCH_LEVEL_TWO_UP_B = 3'h5;
    localparam logic [2:0] OP_PREFETCH_NONTEMPORAL_NEAR = 3'h6;
    localparam logic [2:0] OP_STORE_FENCE = 3'h7;
    // Region memory types
    localparam logic [2:0] MT_UNCACHEABLE_TYPE = 3'h0;
    localparam logic [2:0] MT_WRITE_COMBINING_TYPE = 3'h1;
    localparam logic [2:0] MT_WRITE_THROUGH_TYPE = 3'h4;
    localparam logic [2:0] MT_WRITE_PROTECTED_TYPE = 3'h5;
    localparam logic [2:0] MT_WRITE_BACK_TYPE = 3'h6;
    // Prefetch level masks: bit0 first level, bit1 second, bit2 beyond
    localparam logic [2:0] LVL_ALL = 3'h7;
    localparam logic [2:0] LVL_TWO_UP = 3'h6;
    localparam logic [2:0] LVL_NEAR = 3'h1;
    // Geometry
    localparam int DATA_W = 128;
    localparam int BE_W = 16;
    localparam int QW_W = 64;
    localparam int QB_W = 8;
    localparam int BLK_BITS = 4;
    localparam int PF_ALIGN_BITS = 5;
    // Register map
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_COUNT = 4'h8;
    localparam int CTRL_COMBINE_BIT = 0;
    localparam int CTRL_PF_EN_BIT = 1;
    localparam logic [1:0] CTRL_RESET = 2'h3;
    localparam int STAT_WCB_BIT = 0;
    localparam int STAT_BUS_BIT = 1;
    localparam int COUNT_W = 16;
endpackage

// >>> rtl/ntc_unit.sv
// Non-temporal store combining, prefetch hints and store fence unit
`timescale 1ns/100ps
module ntc_unit #(
    parameter int ADDR_W = 32
) (
    input wire logic I_CLK,
    input wire logic I_RESET_N,
    input wire logic I_OP_VALID,
    output logic O_OP_READY,
    input wire logic [2:0] I_OP_CODE,
    input wire logic [ADDR_W-1:0] I_OP_ADDR,
    input wire logic [127:0] I_OP_DATA,
    input wire logic [7:0] I_OP_MASK,
    input wire logic [2:0] I_MEM_TYPE,
    output logic O_EVICT_VALID,
    output logic [ADDR_W-1:0] O_EVICT_ADDR,
    output logic O_BUS_VALID,
    input wire logic I_BUS_READY,
    output logic [ADDR_W-1:0] O_BUS_ADDR,
    output logic [127:0] O_BUS_DATA,
    output logic [15:0] O_BUS_BE,
    output logic [2:0] O_BUS_TYPE,
    output logic O_PF_VALID,
    output logic [ADDR_W-1:0] O_PF_ADDR,
    output logic [2:0] O_PF_LEVELS,
    output logic O_PF_NT,
    output logic O_FENCE_DONE,
    input wire logic [3:0] I_REG_ADDR,
    input wire logic [31:0] I_REG_WDATA,
    input wire logic I_REG_WR,
    input wire logic I_REG_RD,
    output logic [31:0] O_REG_RDATA
);
    localparam int BW = ADDR_W - ntc_pkg::BLK_BITS;

    // Block address must leave room above the prefetch alignment
    if (ADDR_W < 8 || ADDR_W > 64) begin : g_chk
        $error("ntc_unit: ADDR_W out of range");
    end

    ////////////////////////////////////////////////////////////////////
    // Operation decode
    logic op_st, op_pf, op_fence, cacheable, combine_en, pf_en;
    logic [BW-1:0] op_blk;
    logic [127:0] st_data;
    logic [15:0] st_be;
    logic [7:0] qw_mask;
    logic flush_first, fire, flush_go;
    logic wcb_valid_q, wcb_valid_d, bus_valid_q, bus_valid_d;
    logic [BW-1:0] wcb_blk_q, wcb_blk_d;
    logic [127:0] wcb_data_q, wcb_data_d, bus_data_q, bus_data_d;
    logic [15:0] wcb_be_q, wcb_be_d, bus_be_q, bus_be_d;
    logic [ADDR_W-1:0] bus_addr_q, bus_addr_d;
    logic [ADDR_W-1:0] evict_addr_q, evict_addr_d;
    logic [ADDR_W-1:0] pf_addr_q, pf_addr_d;
    logic [2:0] bus_type_q, bus_type_d, pf_lvl_q, pf_lvl_d;
    logic [2:0] pf_kind_q, pf_kind_d;
    logic evict_q, evict_d, pf_valid_q, pf_valid_d, pf_nt_q, pf_nt_d;
    logic fence_q, fence_d;
    logic [1:0] ctrl_q, ctrl_d;
    logic [ntc_pkg::COUNT_W-1:0] count_q, count_d;
    logic [31:0] rdata_q, rdata_d;

    assign op_st = I_OP_CODE <= ntc_pkg::OP_MASKED_BYTE_STORE_QUADWORD;
    assign op_fence = I_OP_CODE == ntc_pkg::OP_STORE_FENCE;
    assign op_pf = !op_st && !op_fence;
    assign op_blk = I_OP_ADDR[ADDR_W-1:ntc_pkg::BLK_BITS];
    assign combine_en = ctrl_q[ntc_pkg::CTRL_COMBINE_BIT];
    assign pf_en = ctrl_q[ntc_pkg::CTRL_PF_EN_BIT];
    // Only the cacheable types are steered to combining
    assign cacheable = I_MEM_TYPE == ntc_pkg::MT_WRITE_BACK_TYPE ||
        I_MEM_TYPE == ntc_pkg::MT_WRITE_THROUGH_TYPE ||
        I_MEM_TYPE == ntc_pkg::MT_WRITE_COMBINING_TYPE;

    // Lane placement; quadwords use the half picked by address bit 3
    always_comb begin
        qw_mask = 8'hff;
        if (I_OP_CODE == ntc_pkg::OP_MASKED_BYTE_STORE_QUADWORD) begin
            qw_mask = I_OP_MASK;
        end
        if (I_OP_CODE == ntc_pkg::OP_NT_STORE_PACKED_SINGLE) begin
            st_data = I_OP_DATA;
            st_be = 16'hffff;
        end else if (I_OP_ADDR[3]) begin
            st_data = {I_OP_DATA[ntc_pkg::QW_W-1:0], 64'h0};
            st_be = {qw_mask, 8'h00};
        end else begin
            st_data = {64'h0, I_OP_DATA[ntc_pkg::QW_W-1:0]};
            st_be = {8'h00, qw_mask};
        end
    end

    // A fence, or a store that bypasses the buffer, drains it first
    assign flush_first = wcb_valid_q && (op_fence ||
        (op_st && !(cacheable && combine_en)));
    assign O_OP_READY = !bus_valid_q && !flush_first;
    assign fire = I_OP_VALID && O_OP_READY;
    assign flush_go = I_OP_VALID && !bus_valid_q && flush_first;

    ////////////////////////////////////////////////////////////////////
    // Combining buffer, bus write, eviction and prefetch requests
    always_comb begin
        wcb_valid_d = wcb_valid_q;
        wcb_blk_d = wcb_blk_q;
        wcb_data_d = wcb_data_q;
        wcb_be_d = wcb_be_q;
        bus_valid_d = bus_valid_q && !I_BUS_READY;
        bus_addr_d = bus_addr_q;
        bus_data_d = bus_data_q;
        bus_be_d = bus_be_q;
        bus_type_d = bus_type_q;
        evict_d = 1'b0;
        evict_addr_d = evict_addr_q;
        pf_valid_d = 1'b0;
        pf_addr_d = pf_addr_q;
        pf_lvl_d = pf_lvl_q;
        pf_nt_d = pf_nt_q;
        pf_kind_d = pf_kind_q;
        fence_d = 1'b0;
        if (flush_go) begin
            // Drain the combined block so other agents see it
            bus_valid_d = 1'b1;
            bus_addr_d = {wcb_blk_q, 4'h0};
            bus_data_d = wcb_data_q;
            bus_be_d = wcb_be_q;
            bus_type_d = ntc_pkg::MT_WRITE_COMBINING_TYPE;
            wcb_valid_d = 1'b0;
        end else if (fire && op_st) begin
            if (cacheable) begin
                evict_d = 1'b1;
                evict_addr_d = {op_blk, 4'h0};
            end
            if (cacheable && combine_en) begin
                if (wcb_valid_q && wcb_blk_q == op_blk) begin
                    // Same block: merge lanes, no extra bus write
                    for (int b = 0; b < ntc_pkg::BE_W; b++) begin
                        if (st_be[b]) begin
                            wcb_data_d[b*8 +: 8] = st_data[b*8 +: 8];
                        end
                    end
                    wcb_be_d = wcb_be_q | st_be;
                end else begin
                    if (wcb_valid_q) begin
                        bus_valid_d = 1'b1;
                        bus_addr_d = {wcb_blk_q, 4'h0};
                        bus_data_d = wcb_data_q;
                        bus_be_d = wcb_be_q;
                        bus_type_d = ntc_pkg::MT_WRITE_COMBINING_TYPE;
                    end
                    // Held locally, never filled from memory
                    wcb_valid_d = 1'b1;
                    wcb_blk_d = op_blk;
                    wcb_data_d = st_data;
                    wcb_be_d = st_be;
                end
            end else begin
                bus_valid_d = 1'b1;
                bus_addr_d = {op_blk, 4'h0};
                bus_data_d = st_data;
                bus_be_d = st_be;
                // Cacheable goes out combining; otherwise region type rules
                bus_type_d = cacheable ?
                    ntc_pkg::MT_WRITE_COMBINING_TYPE : I_MEM_TYPE;
            end
        end else if (fire && op_pf && pf_en) begin
            // Disabled prefetches are dropped with no visible effect
            pf_valid_d = 1'b1;
            pf_kind_d = I_OP_CODE;
            pf_addr_d = {I_OP_ADDR[ADDR_W-1:ntc_pkg::PF_ALIGN_BITS],
                5'h00};
            pf_nt_d = 1'b0;
            case (I_OP_CODE)
                ntc_pkg::OP_PREFETCH_ALL_LEVELS: begin
                    pf_lvl_d = ntc_pkg::LVL_ALL;
                end
                ntc_pkg::OP_PREFETCH_LEVEL_TWO_UP_A,
                ntc_pkg::OP_PREFETCH_LEVEL_TWO_UP_B: begin
                    pf_lvl_d = ntc_pkg::LVL_TWO_UP;
                end
                default: begin
                    pf_lvl_d = ntc_pkg::LVL_NEAR;
                    pf_nt_d = 1'b1;
                end
            endcase
        end else if (fire && op_fence) begin
            // Buffer is empty and bus idle here, so all is visible
            fence_d = 1'b1;
        end
    end

    // Registering of the datapath group
    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            wcb_valid_q <= 1'b0;
            wcb_blk_q <= '0;
            wcb_data_q <= '0;
            wcb_be_q <= '0;
            bus_valid_q <= 1'b0;
            bus_addr_q <= '0;
            bus_data_q <= '0;
            bus_be_q <= '0;
            bus_type_q <= '0;
            evict_q <= 1'b0;
            evict_addr_q <= '0;
            pf_valid_q <= 1'b0;
            pf_addr_q <= '0;
            pf_lvl_q <= '0;
            pf_nt_q <= 1'b0;
            pf_kind_q <= '0;
            fence_q <= 1'b0;
        end else begin
            wcb_valid_q <= wcb_valid_d;
            wcb_blk_q <= wcb_blk_d;
            wcb_data_q <= wcb_data_d;
            wcb_be_q <= wcb_be_d;
            bus_valid_q <= bus_valid_d;
            bus_addr_q <= bus_addr_d;
            bus_data_q <= bus_data_d;
            bus_be_q <= bus_be_d;
            bus_type_q <= bus_type_d;
            evict_q <= evict_d;
            evict_addr_q <= evict_addr_d;
            pf_valid_q <= pf_valid_d;
            pf_addr_q <= pf_addr_d;
            pf_lvl_q <= pf_lvl_d;
            pf_nt_q <= pf_nt_d;
            pf_kind_q <= pf_kind_d;
            fence_q <= fence_d;
        end
    end

    assign O_BUS_VALID = bus_valid_q;
    assign O_BUS_ADDR = bus_addr_q;
    assign O_BUS_DATA = bus_data_q;
    assign O_BUS_BE = bus_be_q;
    assign O_BUS_TYPE = bus_type_q;
    assign O_EVICT_VALID = evict_q;
    assign O_EVICT_ADDR = evict_addr_q;
    assign O_PF_VALID = pf_valid_q;
    assign O_PF_ADDR = pf_addr_q;
    assign O_PF_LEVELS = pf_lvl_q;
    assign O_PF_NT = pf_nt_q;
    assign O_FENCE_DONE = fence_q;

    ////////////////////////////////////////////////////////////////////
    // Software registers: control, status, store count
    always_comb begin
        ctrl_d = ctrl_q;
        count_d = count_q;
        rdata_d = 32'h0;
        if (I_REG_WR && I_REG_ADDR == ntc_pkg::REG_CTRL) begin
            ctrl_d = I_REG_WDATA[1:0];
        end
        if (fire && op_st) begin
            count_d = count_q + 16'h1; // Wraps silently
        end
        if (I_REG_RD) begin
            case (I_REG_ADDR)
                ntc_pkg::REG_CTRL: rdata_d = {30'h0, ctrl_q};
                ntc_pkg::REG_STATUS: rdata_d = {30'h0, bus_valid_q,
                    wcb_valid_q};
                ntc_pkg::REG_COUNT: rdata_d = {16'h0, count_q};
                default: rdata_d = 32'h0;
            endcase
        end
    end

    // Read data stands one cycle only, zero otherwise
    always_ff @(posedge I_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            ctrl_q <= ntc_pkg::CTRL_RESET;
            count_q <= '0;
            rdata_q <= '0;
        end else begin
            ctrl_q <= ctrl_d;
            count_q <= count_d;
            rdata_q <= rdata_d;
        end
    end

    assign O_REG_RDATA = rdata_q;

    ////////////////////////////////////////////////////////////////////
    // Checks and coverage
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RESET_N);

    a_fence_drained: assert property (O_FENCE_DONE |->
        !$past(wcb_valid_q) && !$past(bus_valid_q))
        else $error("fence completed with stores pending");
    a_fence_flush: assert property (I_OP_VALID && op_fence &&
        wcb_valid_q && !bus_valid_q |=> O_BUS_VALID && !wcb_valid_q)
        else $error("fence did not drain combining buffer");
    a_pf_align: assert property (O_PF_VALID |->
        O_PF_ADDR[4:0] == 5'h00)
        else $error("prefetch address not 32-byte aligned");
    a_pf_all_lvl: assert property (O_PF_VALID &&
        pf_kind_q == ntc_pkg::OP_PREFETCH_ALL_LEVELS |->
        O_PF_LEVELS == ntc_pkg::LVL_ALL && !O_PF_NT)
        else $error("level-zero prefetch not to all levels");
    a_pf_two_up: assert property (fire &&
        (I_OP_CODE == ntc_pkg::OP_PREFETCH_LEVEL_TWO_UP_A ||
        I_OP_CODE == ntc_pkg::OP_PREFETCH_LEVEL_TWO_UP_B) && pf_en |=>
        O_PF_VALID && !O_PF_LEVELS[0] && O_PF_LEVELS[1])
        else $error("level-one/two prefetch reached first level");
    a_pf_nt_near: assert property (fire && pf_en &&
        I_OP_CODE == ntc_pkg::OP_PREFETCH_NONTEMPORAL_NEAR |=>
        O_PF_NT && O_PF_LEVELS == ntc_pkg::LVL_NEAR)
        else $error("non-temporal prefetch wrongly placed");
    a_pf_dropped: assert property (fire && op_pf && !pf_en |=>
        !O_PF_VALID && $stable(O_BUS_VALID))
        else $error("disabled prefetch was issued");
    a_nt_evict: assert property (fire && op_st && cacheable |=>
        O_EVICT_VALID && O_EVICT_ADDR[ADDR_W-1:4] == $past(op_blk))
        else $error("cacheable store did not evict");
    a_uc_type_wins: assert property (fire && op_st && !cacheable |=>
        O_BUS_VALID && O_BUS_TYPE == $past(I_MEM_TYPE))
        else $error("uncacheable store lost its region type");
    a_no_alloc: assert property (fire && op_st |=> !O_PF_VALID)
        else $error("store caused a line fetch");

    c_merge: cover property (fire && op_st && wcb_valid_q &&
        wcb_blk_q == op_blk && combine_en);
    c_fence_flush: cover property (flush_go && op_fence ##[1:8]
        O_FENCE_DONE);
    c_uc_store: cover property (fire && op_st && !cacheable);
    c_pf_nt: cover property (O_PF_VALID && O_PF_NT);
endmodule

// >>> tb/ntc_mem_model.sv
// Behavioural system bus and memory behind the unit, with stalls
`timescale 1ns/100ps
module ntc_mem_model (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_valid,
    input wire logic i_stall,
    input wire logic [31:0] i_addr,
    input wire logic [127:0] i_data,
    input wire logic [15:0] i_be,
    output logic o_ready
);
    logic [7:0] mem [logic [31:0]];

    ////////////////////////////////////////////////////////////////////////
    // Ready lags the stall request a cycle, like a busy shared bus
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_ready <= 1'b0;
        end else begin
            o_ready <= !i_stall;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Accepted bytes are seen by every other agent at once
    always @(posedge i_clk) begin
        if (i_valid && o_ready) begin
            for (int b = 0; b < 16; b++) begin
                if (i_be[b]) begin
                    mem[{i_addr[31:4], 4'h0} + b] = i_data[8*b +: 8];
                end
            end
        end
    end
endmodule

// >>> tb/test_nontemporal_store_prefetch_fence.sv
// Self-checking bench for the non-temporal store, prefetch and fence unit
`timescale 1ns/100ps
module test_nontemporal_store_prefetch_fence;
    logic clk, rst_n, op_valid, op_ready, bus_valid, bus_ready, stall;
    logic evict_valid, pf_valid, pf_nt, fence_done, reg_wr, reg_rd;
    logic [2:0] op_code, mem_type, bus_type, pf_levels, last_type;
    logic [31:0] op_addr, evict_addr, bus_addr, pf_addr, reg_wdata, reg_rdata;
    logic [127:0] op_data, bus_data;
    logic [7:0] op_mask;
    logic [15:0] bus_be, last_be;
    logic [3:0] reg_addr;
    logic [1:0] ctrl;
    logic [7:0] ref_mem [logic [31:0]];
    int miscompares, comparisons, bus_writes, stores, seed, r, w;
    // Fixed type per 16-byte block so every region type is visited
    logic [2:0] region [8] = '{ntc_pkg::MT_WRITE_BACK_TYPE,
        ntc_pkg::MT_WRITE_THROUGH_TYPE, ntc_pkg::MT_WRITE_COMBINING_TYPE,
        ntc_pkg::MT_UNCACHEABLE_TYPE, ntc_pkg::MT_WRITE_PROTECTED_TYPE,
        ntc_pkg::MT_WRITE_BACK_TYPE, ntc_pkg::MT_WRITE_COMBINING_TYPE,
        ntc_pkg::MT_UNCACHEABLE_TYPE};

    ntc_unit ntc_unit_i (.I_CLK(clk), .I_RESET_N(rst_n),
        .I_OP_VALID(op_valid), .O_OP_READY(op_ready), .I_OP_CODE(op_code),
        .I_OP_ADDR(op_addr), .I_OP_DATA(op_data), .I_OP_MASK(op_mask),
        .I_MEM_TYPE(mem_type), .O_EVICT_VALID(evict_valid),
        .O_EVICT_ADDR(evict_addr), .O_BUS_VALID(bus_valid),
        .I_BUS_READY(bus_ready), .O_BUS_ADDR(bus_addr), .O_BUS_DATA(bus_data),
        .O_BUS_BE(bus_be), .O_BUS_TYPE(bus_type), .O_PF_VALID(pf_valid),
        .O_PF_ADDR(pf_addr), .O_PF_LEVELS(pf_levels), .O_PF_NT(pf_nt),
        .O_FENCE_DONE(fence_done), .I_REG_ADDR(reg_addr),
        .I_REG_WDATA(reg_wdata), .I_REG_WR(reg_wr), .I_REG_RD(reg_rd),
        .O_REG_RDATA(reg_rdata));
    ntc_mem_model model_i (.i_clk(clk), .i_reset_n(rst_n),
        .i_valid(bus_valid), .i_stall(stall), .i_addr(bus_addr),
        .i_data(bus_data), .i_be(bus_be), .o_ready(bus_ready));

    ////////////////////////////////////////////////////////////////////////
    // Clock, random bus stalls and hang guard
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk) begin
        stall <= ($random(seed) % 4) == 0;
    end
    initial begin
        repeat (40000) @(posedge clk);
        miscompares++;
        end_of_test();
    end

    ////////////////////////////////////////////////////////////////////////
    // Comparison, verdict and expectation helpers
    task automatic check(string name, logic [127:0] seen, logic [127:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic end_of_test();
        if (miscompares == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    function automatic logic cacheable(logic [2:0] t);
        return t == ntc_pkg::MT_WRITE_BACK_TYPE ||
            t == ntc_pkg::MT_WRITE_THROUGH_TYPE ||
            t == ntc_pkg::MT_WRITE_COMBINING_TYPE;
    endfunction
    function automatic logic [2:0] levels(logic [2:0] c);
        if (c == ntc_pkg::OP_PREFETCH_ALL_LEVELS) return ntc_pkg::LVL_ALL;
        if (c == ntc_pkg::OP_PREFETCH_NONTEMPORAL_NEAR) return ntc_pkg::LVL_NEAR;
        return ntc_pkg::LVL_TWO_UP;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Bus monitor: cacheable regions must go out as combining writes
    always @(posedge clk) begin
        if (bus_valid && bus_ready) begin
            bus_writes++;
            last_be = bus_be;
            last_type = bus_type;
            check("bus type", bus_type, cacheable(region[bus_addr[6:4]]) ?
                ntc_pkg::MT_WRITE_COMBINING_TYPE :
                region[bus_addr[6:4]]);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register port master
    task automatic reg_write(logic [3:0] a, logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
        if (a == ntc_pkg::REG_CTRL) ctrl = d[1:0];
    endtask
    task automatic reg_read(logic [3:0] a, logic [31:0] exp, string name);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        check(name, reg_rdata, exp);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // One operation: held until taken, then the one-cycle answer checked
    task automatic op(logic [2:0] c, logic [31:0] a, logic [127:0] d,
                      logic [7:0] m);
        logic [2:0] t;
        int n;
        t = region[a[6:4]];
        @(posedge clk);
        op_valid <= 1'b1;
        op_code <= c;
        op_addr <= a;
        op_data <= d;
        op_mask <= m;
        mem_type <= t;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (op_ready !== 1'b1 && n < 200);
        @(posedge clk);
        op_valid <= 1'b0;
        op_data <= ~d;
        @(negedge clk);
        if (c <= ntc_pkg::OP_MASKED_BYTE_STORE_QUADWORD) begin
            stores++;
            for (int b = 0; b < 16; b++) begin
                if (c == ntc_pkg::OP_NT_STORE_PACKED_SINGLE) begin
                    ref_mem[{a[31:4], 4'h0} + b] = d[8*b +: 8];
                end else if (b < 8 && (c == 3'h0 || m[b])) begin
                    ref_mem[{a[31:3], 3'h0} + b] = d[8*b +: 8];
                end
            end
            check("evict", evict_valid, cacheable(t));
            if (cacheable(t)) check("evict addr", evict_addr, a & ~32'hf);
            check("no fill", pf_valid, 1'b0);
        end else if (c == ntc_pkg::OP_STORE_FENCE) begin
            check("fence done", fence_done, 1'b1);
            foreach (ref_mem[k]) check("memory", model_i.mem.exists(k) ?
                model_i.mem[k] : 8'hxx, ref_mem[k]);
        end else begin
            check("prefetch", pf_valid, ctrl[1]);
            if (ctrl[1]) begin
                check("pf addr", pf_addr, a & ~32'h1f);
                check("pf levels", pf_levels, levels(c));
                check("pf nt", pf_nt, c == 3'h6);
            end
        end
        check("op taken", n < 200, 1'b1);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence: reset, corner cases, then random traffic
    initial begin
        seed = 99324;
        {rst_n, op_valid, reg_wr, reg_rd} = '0;
        {op_code, op_addr, op_data, op_mask, mem_type} = '0;
        {reg_addr, reg_wdata} = '0;
        ctrl = 2'h3;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        reg_read(ntc_pkg::REG_CTRL, 32'h3, "ctrl reset");
        reg_read(ntc_pkg::REG_STATUS, 32'h0, "status reset");
        reg_read(ntc_pkg::REG_COUNT, 32'h0, "count reset");
        reg_write(4'hc, 32'hffffffff);
        reg_read(4'hc, 32'h0, "unmapped");
        // Uncacheable target bypasses the buffer, upper half lane
        op(3'h0, 32'h38, 128'h1122334455667788, 8'h0);
        op(ntc_pkg::OP_STORE_FENCE, 32'h0, '0, 8'h0);
        check("bypass be", last_be, 16'hff00);
        check("bypass type", last_type, ntc_pkg::MT_UNCACHEABLE_TYPE);
        // Two stores to one write-back block merge into one write
        w = bus_writes;
        op(3'h0, 32'h100, 128'hdeadbeefcafef00d, 8'h0);
        op(3'h2, 32'h108, 128'h0102030405060708, 8'h5a);
        reg_read(ntc_pkg::REG_STATUS, 32'h1, "buffer holds");
        op(ntc_pkg::OP_STORE_FENCE, 32'h0, '0, 8'h0);
        check("merged writes", bus_writes - w, 1);
        check("merged be", last_be, 16'h5aff);
        check("merged type", last_type, ntc_pkg::MT_WRITE_COMBINING_TYPE);
        // Every prefetch hint, then dropped with prefetch disabled
        for (int c = 3; c < 7; c++) op(3'(c), 32'h1234567, '0, 8'h0);
        reg_write(ntc_pkg::REG_CTRL, 32'h1);
        op(ntc_pkg::OP_PREFETCH_ALL_LEVELS, 32'h40, '0, 8'h0);
        for (int i = 0; i < 400; i++) begin
            r = $random(seed);
            if (r[31:28] == 4'h0) reg_write(ntc_pkg::REG_CTRL, {30'h0, r[1:0]});
            op(r[2:0], {24'h0, r[15:8]}, {$random(seed), $random(seed),
                $random(seed), $random(seed)}, r[23:16]);
        end
        op(ntc_pkg::OP_STORE_FENCE, 32'h0, '0, 8'h0);
        reg_read(ntc_pkg::REG_COUNT, stores & 32'hffff, "store count");
        end_of_test();
    end
endmodule
